// >>> src/ccr_pkg.sv
/*
 * ccr_pkg: shared constants and types for the cpu core register block.
 * Assumes a single core clock at 100 MHz and an active high async reset.
 */
package ccr_pkg;

    ////////////////////////////////////////////////////////////////////////
    // data-space locations of the core registers
    localparam logic [7:0] CCR_ADDR_PTR_ONE    = 8'h80;
    localparam logic [7:0] CCR_ADDR_PTR_TWO    = 8'h81;
    localparam logic [7:0] CCR_ADDR_SHORT_ONE  = 8'h82;
    localparam logic [7:0] CCR_ADDR_SHORT_TWO  = 8'h83;
    localparam logic [7:0] CCR_ADDR_RESULT     = 8'hFF;

    ////////////////////////////////////////////////////////////////////////
    // widths and sizes
    localparam int         CCR_DW              = 8;
    localparam int         CCR_PCW             = 12;
    localparam int         CCR_STACK_DEPTH     = 6;
    localparam int         CCR_BANKW           = 2;

    // vectors; plain defaults, the chip decides the real map
    localparam logic [11:0] CCR_RESET_VECTOR   = 12'hFFE;
    localparam logic [11:0] CCR_IRQ_VECTOR     = 12'hFF0;
    localparam logic [11:0] CCR_NMI_VECTOR     = 12'hFFC;

    ////////////////////////////////////////////////////////////////////////
    // machine cycle timing: core clock divided by 13
    localparam int         CCR_MC_DIV          = 13;
    localparam logic [3:0] CCR_MC_LAST         = 4'(CCR_MC_DIV - 1);
    localparam logic [3:0] CCR_MC_RESET        = 4'h0;
    localparam logic [2:0] CCR_CYC_RESET       = 3'h0;

    ////////////////////////////////////////////////////////////////////////
    // types
    typedef enum logic [1:0] {
        CCR_CTX_NORMAL,
        CCR_CTX_IRQ,
        CCR_CTX_NMI
    } ccr_ctx_t;

    typedef enum logic [2:0] {
        CCR_OP_SEQ,
        CCR_OP_JUMP,
        CCR_OP_CALL,
        CCR_OP_BRANCH,
        CCR_OP_SUB_EXIT,
        CCR_OP_IRQ_EXIT,
        CCR_OP_IRQ,
        CCR_OP_NMI
    } ccr_op_t;

    typedef enum logic {
        CCR_ST_IDLE,
        CCR_ST_BUSY
    } ccr_state_t;

endpackage

// >>> src/ccr_stack.sv
/*
 * ccr_stack: six-level 12-bit return stack with no pointer visible to code.
 * Assumes push and pop are never asserted together by the owner.
 */
`timescale 1ns/1ps

module ccr_stack
    import ccr_pkg::*;
(
    input  wire logic                 core_clk,
    input  wire logic                 rst,
    input  wire logic                 push,
    input  wire logic                 pop,
    input  wire logic [CCR_PCW-1:0]   push_data,
    output logic      [CCR_PCW-1:0]   top_data,
    output logic                      empty
);

    logic [CCR_PCW-1:0] lvl_r   [CCR_STACK_DEPTH];
    logic [CCR_PCW-1:0] lvl_nxt [CCR_STACK_DEPTH];
    logic [2:0]         fill_r;
    logic [2:0]         fill_nxt;

    ////////////////////////////////////////////////////////////////////////
    // per level shift: up on push, down on pop
    for (genvar i = 0; i < CCR_STACK_DEPTH; i++) begin : g_lvl
        always_comb begin
            lvl_nxt[i] = lvl_r[i];
            if (push) begin
                lvl_nxt[i] = (i == 0) ? push_data : lvl_r[(i == 0) ? 0 : i - 1];
            end else if (pop && fill_r != 3'h0) begin
                // bottom level keeps its old copy, level six drops out on push
                lvl_nxt[i] = (i == CCR_STACK_DEPTH - 1) ? lvl_r[i] : lvl_r[(i == CCR_STACK_DEPTH - 1) ? i : i + 1];
            end
        end

        // contents carry no reset; software never sees an unpushed level
        always_ff @(posedge core_clk) begin
            lvl_r[i] <= lvl_nxt[i];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // fill level saturates both ways, no error signalled
    always_comb begin
        fill_nxt = fill_r;
        if (push && fill_r != 3'(CCR_STACK_DEPTH)) begin
            fill_nxt = fill_r + 3'h1;
        end else if (pop && fill_r != 3'h0) begin
            fill_nxt = fill_r - 3'h1;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            fill_r <= 3'h0;
        end else begin
            fill_r <= fill_nxt;
        end
    end

    assign top_data = lvl_r[0];
    assign empty    = (fill_r == 3'h0);

endmodule

// >>> src/ccr_flags.sv
/*
 * ccr_flags: three carry/zero pairs, one per execution context.
 * Assumes the owner presents the current context on ctx every cycle.
 */
`timescale 1ns/1ps

module ccr_flags
    import ccr_pkg::*;
(
    input  wire logic      core_clk,
    input  wire logic      rst,
    input  ccr_ctx_t       ctx,
    input  wire logic      carry_we,
    input  wire logic      carry_in,
    input  wire logic      zero_we,
    input  wire logic      zero_in,
    output logic           carry_out,
    output logic           zero_out,
    output logic [2:0]     carry_all,
    output logic [2:0]     zero_all
);

    logic [2:0] carry_r;
    logic [2:0] carry_nxt;
    logic [2:0] zero_r;
    logic [2:0] zero_nxt;

    ////////////////////////////////////////////////////////////////////////
    // only the pair of the live context ever changes; others hold
    for (genvar i = 0; i < 3; i++) begin : g_pair
        always_comb begin
            carry_nxt[i] = carry_r[i];
            zero_nxt[i]  = zero_r[i];
            if (ctx == ccr_ctx_t'(i)) begin
                if (carry_we) begin
                    carry_nxt[i] = carry_in;
                end
                if (zero_we) begin
                    zero_nxt[i] = zero_in;
                end
            end
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            carry_r <= 3'h0;
            zero_r  <= 3'h0;
        end else begin
            carry_r <= carry_nxt;
            zero_r  <= zero_nxt;
        end
    end

    assign carry_out = carry_r[ctx];
    assign zero_out  = zero_r[ctx];
    assign carry_all = carry_r;
    assign zero_all  = zero_r;

endmodule

// >>> src/ccr_core.sv
/*
 * ccr_core: programmer-visible state of the 8-bit cpu core: data-space
 * registers, instruction pointer, flag banks, return stack, machine cycle.
 * Assumes a sequencer that issues one op at a time with its cycle count,
 * an alu that reports results, and a data-space bus that decodes addresses.
 */
// Function
// - 8-bit result register used by all operations, data-space address FFh.
// - pointer registers at 80h and 81h, usable indirectly and directly.
// - short-direct registers at 82h and 83h, also directly addressable.
// - 12-bit instruction pointer addresses 4096 program bytes.
// - program space beyond 4096 bytes reached via a bank switch value.
// - pointer increments after fetch; relative jump adds offset via adder.
// - pointer loads jump, call, relative, interrupt and reset targets.
// - returns load stack top; ordinary instructions advance pointer by one.
// - three carry/zero pairs: normal, interrupt, non-maskable.
// - interrupt entry switches flag pair; irq exit restores previous pair.
// - pairs never cleared on switch; each reachable only in its context.
// - carry from arithmetic carry/borrow, bit test, used by rotate.
// - zero set when last arithmetic or logic result is zero.
// - after reset the non-maskable context and its flag pair are live.
// - six-level 12-bit lifo stack outside data space.
// - call or interrupt shifts levels up, pointer into level one.
// - return moves level one to pointer, shifts levels down.
// - over six nestings stack stays deepest, oldest lost, no error.
// - return on empty stack keeps stack, continues with next instruction.
// - machine cycle is the core clock divided by 13.
// - instructions take two, four or five machine cycles.
`timescale 1ns/1ps

module ccr_core
    import ccr_pkg::*;
(
    input  wire logic                  core_clk,
    input  wire logic                  rst,
    // sequencer op port
    input  wire logic                  op_valid,
    output logic                       op_ready,
    input  ccr_op_t                    op_code,
    input  wire logic [2:0]            op_cycles,
    input  wire logic [CCR_PCW-1:0]    op_target,
    input  wire logic [CCR_DW-1:0]     op_offset,
    output logic                       op_done,
    output logic                       mc_tick,
    // program memory side
    input  wire logic                  fetch_inc,
    input  wire logic [CCR_BANKW-1:0]  bank_sel,
    output logic [CCR_PCW-1:0]         instr_pointer,
    output logic [CCR_BANKW-1:0]       pm_bank,
    // data-space bus
    input  wire logic [7:0]            ds_addr,
    input  wire logic                  ds_wr,
    input  wire logic [CCR_DW-1:0]     ds_wdata,
    input  wire logic                  ds_rd,
    output logic [CCR_DW-1:0]          ds_rdata,
    output logic                       ds_rvalid,
    output logic                       ds_hit,
    // alu side
    input  wire logic                  alu_we,
    input  wire logic [CCR_DW-1:0]     alu_result,
    input  wire logic                  carry_we,
    input  wire logic                  carry_in,
    input  wire logic                  zero_we,
    input  wire logic                  zero_in,
    output logic                       carry_out,
    output logic                       zero_out,
    output logic [CCR_DW-1:0]          result_q,
    output logic [CCR_DW-1:0]          pointer_one_q,
    output logic [CCR_DW-1:0]          pointer_two_q,
    output ccr_ctx_t                   ctx_q
);

    ////////////////////////////////////////////////////////////////////////
    // declarations
    logic [CCR_DW-1:0]   result_reg_r,        result_reg_nxt;
    logic [CCR_DW-1:0]   pointer_one_r,       pointer_one_nxt;
    logic [CCR_DW-1:0]   pointer_two_r,       pointer_two_nxt;
    logic [CCR_DW-1:0]   short_slot_first_r,  short_slot_first_nxt;
    logic [CCR_DW-1:0]   short_slot_second_r, short_slot_second_nxt;
    logic [CCR_DW-1:0]   rdata_r,             rdata_nxt;
    logic                rvalid_r,            rvalid_nxt;
    logic [3:0]          mc_cnt_r,            mc_cnt_nxt;
    ccr_state_t          state_r,             state_nxt;
    ccr_op_t             op_r,                op_nxt;
    logic [2:0]          left_r,              left_nxt;
    logic [CCR_PCW-1:0]  tgt_r,               tgt_nxt;
    logic [CCR_DW-1:0]   off_r,               off_nxt;
    logic [CCR_PCW-1:0]  ip_r,                ip_nxt;
    logic [CCR_BANKW-1:0] bank_r,             bank_nxt;
    ccr_ctx_t            ctx_r,               ctx_nxt;
    ccr_ctx_t            sav0_r,              sav0_nxt;
    ccr_ctx_t            sav1_r,              sav1_nxt;
    logic [1:0]          sav_cnt_r,           sav_cnt_nxt;
    logic                commit;
    logic                push;
    logic                pop;
    logic                stk_empty;
    logic [CCR_PCW-1:0]  stk_top;
    logic [CCR_PCW-1:0]  rel_sum;

    ////////////////////////////////////////////////////////////////////////
    // data-space registers; bus write beats an alu write to the result
    always_comb begin
        result_reg_nxt        = result_reg_r;
        pointer_one_nxt       = pointer_one_r;
        pointer_two_nxt       = pointer_two_r;
        short_slot_first_nxt  = short_slot_first_r;
        short_slot_second_nxt = short_slot_second_r;
        if (alu_we) begin
            result_reg_nxt = alu_result;
        end
        if (ds_wr) begin
            unique case (ds_addr)
                CCR_ADDR_RESULT:    result_reg_nxt        = ds_wdata;
                CCR_ADDR_PTR_ONE:   pointer_one_nxt       = ds_wdata;
                CCR_ADDR_PTR_TWO:   pointer_two_nxt       = ds_wdata;
                CCR_ADDR_SHORT_ONE: short_slot_first_nxt  = ds_wdata;
                CCR_ADDR_SHORT_TWO: short_slot_second_nxt = ds_wdata;
                default:            ;
            endcase
        end
    end

    // no reset on purpose: contents are undefined until software sets them
    always_ff @(posedge core_clk) begin
        result_reg_r        <= result_reg_nxt;
        pointer_one_r       <= pointer_one_nxt;
        pointer_two_r       <= pointer_two_nxt;
        short_slot_first_r  <= short_slot_first_nxt;
        short_slot_second_r <= short_slot_second_nxt;
    end

    ////////////////////////////////////////////////////////////////////////
    // read path: one cycle to data, only for our five locations
    always_comb begin
        ds_hit    = 1'b1;
        rdata_nxt = rdata_r;
        unique case (ds_addr)
            CCR_ADDR_RESULT:    rdata_nxt = result_reg_r;
            CCR_ADDR_PTR_ONE:   rdata_nxt = pointer_one_r;
            CCR_ADDR_PTR_TWO:   rdata_nxt = pointer_two_r;
            CCR_ADDR_SHORT_ONE: rdata_nxt = short_slot_first_r;
            CCR_ADDR_SHORT_TWO: rdata_nxt = short_slot_second_r;
            default:            ds_hit    = 1'b0;
        endcase
        if (!ds_rd) begin
            rdata_nxt = rdata_r;
        end
        rvalid_nxt = ds_rd && ds_hit;
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            rdata_r  <= 8'h00;
            rvalid_r <= 1'b0;
        end else begin
            rdata_r  <= rdata_nxt;
            rvalid_r <= rvalid_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // machine cycle divider and op sequencing
    always_comb begin
        mc_cnt_nxt = (mc_cnt_r == CCR_MC_LAST) ? CCR_MC_RESET : mc_cnt_r + 4'h1;
        state_nxt  = state_r;
        op_nxt     = op_r;
        left_nxt   = left_r;
        tgt_nxt    = tgt_r;
        off_nxt    = off_r;
        commit     = 1'b0;
        unique case (state_r)
            CCR_ST_IDLE: begin
                if (op_valid) begin
                    state_nxt = CCR_ST_BUSY;
                    op_nxt    = op_code;
                    // a zero count would wrap to seven and run eight ticks, so treat it as one
                    left_nxt  = (op_cycles == 3'h0) ? 3'h1 : op_cycles;
                    tgt_nxt   = op_target;
                    off_nxt   = op_offset;
                end
            end
            CCR_ST_BUSY: begin
                if (mc_tick) begin
                    left_nxt = left_r - 3'h1;
                    if (left_r == 3'h1) begin
                        commit    = 1'b1;
                        state_nxt = CCR_ST_IDLE;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            mc_cnt_r <= CCR_MC_RESET;
            state_r  <= CCR_ST_IDLE;
            op_r     <= CCR_OP_SEQ;
            left_r   <= CCR_CYC_RESET;
            tgt_r    <= 12'h000;
            off_r    <= 8'h00;
        end else begin
            mc_cnt_r <= mc_cnt_nxt;
            state_r  <= state_nxt;
            op_r     <= op_nxt;
            left_r   <= left_nxt;
            tgt_r    <= tgt_nxt;
            off_r    <= off_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // instruction pointer, bank and context
    // relative target: offset sign-extended and added in one adder
    assign rel_sum = ip_r + {{(CCR_PCW - CCR_DW){off_r[CCR_DW-1]}}, off_r};

    always_comb begin
        ip_nxt      = ip_r;
        bank_nxt    = bank_sel;
        ctx_nxt     = ctx_r;
        sav0_nxt    = sav0_r;
        sav1_nxt    = sav1_r;
        sav_cnt_nxt = sav_cnt_r;
        push        = 1'b0;
        pop         = 1'b0;
        if (fetch_inc) begin
            ip_nxt = ip_r + 12'h001;
        end
        if (commit) begin
            unique case (op_r)
                CCR_OP_SEQ:    ip_nxt = ip_r + 12'h001;
                CCR_OP_JUMP:   ip_nxt = tgt_r;
                CCR_OP_BRANCH: ip_nxt = rel_sum;
                CCR_OP_CALL: begin
                    push   = 1'b1;
                    ip_nxt = tgt_r;
                end
                CCR_OP_SUB_EXIT, CCR_OP_IRQ_EXIT: begin
                    pop    = 1'b1;
                    // empty stack: fall through to the next instruction
                    ip_nxt = stk_empty ? ip_r + 12'h001 : stk_top;
                    if (op_r == CCR_OP_IRQ_EXIT) begin
                        ctx_nxt     = (sav_cnt_r == 2'h0) ? CCR_CTX_NORMAL : sav0_r;
                        sav0_nxt    = sav1_r;
                        sav_cnt_nxt = (sav_cnt_r == 2'h0) ? 2'h0 : sav_cnt_r - 2'h1;
                    end
                end
                CCR_OP_IRQ, CCR_OP_NMI: begin
                    push        = 1'b1;
                    ip_nxt      = (op_r == CCR_OP_NMI) ? CCR_NMI_VECTOR : CCR_IRQ_VECTOR;
                    ctx_nxt     = (op_r == CCR_OP_NMI) ? CCR_CTX_NMI : CCR_CTX_IRQ;
                    sav0_nxt    = ctx_r;
                    sav1_nxt    = sav0_r;
                    sav_cnt_nxt = (sav_cnt_r == 2'h2) ? 2'h2 : sav_cnt_r + 2'h1;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            ip_r      <= CCR_RESET_VECTOR;
            bank_r    <= 2'h0;
            ctx_r     <= CCR_CTX_NMI;
            sav0_r    <= CCR_CTX_NORMAL;
            sav1_r    <= CCR_CTX_NORMAL;
            sav_cnt_r <= 2'h0;
        end else begin
            ip_r      <= ip_nxt;
            bank_r    <= bank_nxt;
            ctx_r     <= ctx_nxt;
            sav0_r    <= sav0_nxt;
            sav1_r    <= sav1_nxt;
            sav_cnt_r <= sav_cnt_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // return stack and flag banks
    ccr_stack u_stack (
        .core_clk  (core_clk),
        .rst       (rst),
        .push      (push),
        .pop       (pop),
        .push_data (ip_r),
        .top_data  (stk_top),
        .empty     (stk_empty)
    );

    ccr_flags u_flags (
        .core_clk  (core_clk),
        .rst       (rst),
        .ctx       (ctx_r),
        .carry_we  (carry_we),
        .carry_in  (carry_in),
        .zero_we   (zero_we),
        .zero_in   (zero_in),
        .carry_out (carry_out),
        .zero_out  (zero_out),
        .carry_all (),
        .zero_all  ()
    );

    ////////////////////////////////////////////////////////////////////////
    // outputs
    assign mc_tick       = (mc_cnt_r == CCR_MC_LAST);
    assign op_ready      = (state_r == CCR_ST_IDLE);
    assign op_done       = commit;
    assign instr_pointer = ip_r;
    assign pm_bank       = bank_r;
    assign ds_rdata      = rdata_r;
    assign ds_rvalid     = rvalid_r;
    assign result_q      = result_reg_r;
    assign pointer_one_q = pointer_one_r;
    assign pointer_two_q = pointer_two_r;
    assign ctx_q         = ctx_r;

endmodule

// >>> verification/ccr_core_properties.sv
/* ccr_core_props: port checks on the core register block.
   Bound to every ccr_core; sees only its ports. */
`timescale 1ns/1ps

module ccr_core_props
    import ccr_pkg::*;
(
    input wire logic        core_clk,
    input wire logic        rst,
    input wire logic        op_valid,
    input wire logic        op_ready,
    input ccr_op_t          op_code,
    input wire logic [11:0] op_target,
    input wire logic        op_done,
    input wire logic        mc_tick,
    input wire logic        fetch_inc,
    input wire logic [11:0] instr_pointer,
    input ccr_ctx_t         ctx_q,
    input wire logic [7:0]  ds_addr,
    input wire logic        ds_rd,
    input wire logic        ds_hit,
    input wire logic        ds_rvalid
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);

    ////////////////////////////////////////
    // machine cycle and op completion
    tick_period_a: assert property (mc_tick |-> ##13 mc_tick)
        else $error("tick period off");
    done_on_tick_a: assert property (op_done |-> mc_tick)
        else $error("done off tick");
    done_bound_a: assert property (op_valid && op_ready |-> ##[1:66] op_done)
        else $error("op never done");
    // pointer loads, context switch
    jump_load_a: assert property (op_done && op_code == CCR_OP_JUMP |=> instr_pointer == $past(op_target))
        else $error("jump target lost");
    seq_step_a: assert property (fetch_inc && !op_done |=> instr_pointer == $past(instr_pointer) + 12'h001)
        else $error("fetch step wrong");
    irq_entry_a: assert property (op_done && op_code == CCR_OP_IRQ |=> ctx_q == CCR_CTX_IRQ)
        else $error("irq context wrong");
    // data-space decode and read answer
    hit_decode_a: assert property (ds_hit == (ds_addr inside {[8'h80:8'h83], 8'hFF}))
        else $error("decode wrong");
    read_answer_a: assert property (ds_rvalid == ($past(ds_rd) && $past(ds_hit)))
        else $error("read answer wrong");
endmodule

bind ccr_core ccr_core_props u_props (
    .core_clk(core_clk), .rst(rst), .op_valid(op_valid), .op_ready(op_ready), .op_code(op_code),
    .op_target(op_target), .op_done(op_done), .mc_tick(mc_tick), .fetch_inc(fetch_inc),
    .instr_pointer(instr_pointer), .ctx_q(ctx_q), .ds_addr(ds_addr), .ds_rd(ds_rd),
    .ds_hit(ds_hit), .ds_rvalid(ds_rvalid)
);

// >>> verification/ccr_pm_model.sv
/* ccr_pm_model: program memory side, issues fetch strobes.
   Assumes the core's machine tick; enabled by the bench. */
`timescale 1ns/1ps

module ccr_pm_model (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic en,
    input wire logic mc_tick,
    output logic     fetch_inc
);
    // one fetch per machine cycle, the shortest core step
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            fetch_inc <= 1'b0;
        end else begin
            fetch_inc <= en && mc_tick;
        end
    end
endmodule

// >>> verification/cpu_core_regs_flags_stack_tb.sv
/* cpu_core_regs_flags_stack_tb: registers, pointer, flags, stack.
   Drives ccr_core directly; fetch strobes come from ccr_pm_model. */
`timescale 1ns/1ps
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin n_mismatch++; \
    $display("unexpected %s exp %0h got %0h", nm, e, g); end end

module cpu_core_regs_flags_stack_tb;
    import ccr_pkg::*;
    logic core_clk = 0, rst = 1, op_valid = 0, pm_en = 0, ds_wr = 0, ds_rd = 0, alu_we = 0;
    logic carry_we = 0, carry_in = 0, zero_we = 0, zero_in = 0;
    logic op_ready, op_done, mc_tick, fetch_inc, ds_rvalid, ds_hit, carry_out, zero_out;
    ccr_op_t     op_code = CCR_OP_SEQ;
    logic [2:0]  op_cycles = 3'h2;
    logic [11:0] op_target = 12'h000, instr_pointer;
    logic [7:0]  op_offset = 8'h00, ds_addr = 8'h00, ds_wdata = 8'h00, alu_result = 8'h00;
    logic [7:0]  ds_rdata, result_q, pointer_one_q, pointer_two_q;
    logic [1:0]  bank_sel = 2'h0, pm_bank;
    ccr_ctx_t    ctx_q;
    logic [7:0]  amap [5] = '{CCR_ADDR_PTR_ONE, CCR_ADDR_PTR_TWO, CCR_ADDR_SHORT_ONE,
                              CCR_ADDR_SHORT_TWO, CCR_ADDR_RESULT};
    int          n_mismatch = 0, check_count = 0, cyc = 0, i;

    ccr_core uut (.core_clk(core_clk), .rst(rst), .op_valid(op_valid), .op_ready(op_ready),
        .op_code(op_code), .op_cycles(op_cycles), .op_target(op_target), .op_offset(op_offset),
        .op_done(op_done), .mc_tick(mc_tick), .fetch_inc(fetch_inc), .bank_sel(bank_sel),
        .instr_pointer(instr_pointer), .pm_bank(pm_bank), .ds_addr(ds_addr), .ds_wr(ds_wr),
        .ds_wdata(ds_wdata), .ds_rd(ds_rd), .ds_rdata(ds_rdata), .ds_rvalid(ds_rvalid),
        .ds_hit(ds_hit), .alu_we(alu_we), .alu_result(alu_result), .carry_we(carry_we),
        .carry_in(carry_in), .zero_we(zero_we), .zero_in(zero_in), .carry_out(carry_out),
        .zero_out(zero_out), .result_q(result_q), .pointer_one_q(pointer_one_q),
        .pointer_two_q(pointer_two_q), .ctx_q(ctx_q));
    ccr_pm_model u_pm (.core_clk(core_clk), .rst(rst), .en(pm_en), .mc_tick(mc_tick),
        .fetch_inc(fetch_inc));

    ////////////////////////////////////////
    // clock and hang guard; a full run needs under 1000 cycles
    initial forever #5 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 10000) begin
            n_mismatch++;
            close_out();
        end
    end

    task automatic close_out;
        if (n_mismatch == 0 && check_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic ds_write(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        ds_addr <= a;
        ds_wdata <= d;
        ds_wr <= 1'b1;
        @(posedge core_clk);
        ds_wr <= 1'b0;
    endtask

    // answer is looked at in the one cycle it stands
    task automatic ds_read(input logic [7:0] a, input logic h, input logic [7:0] e);
        @(posedge core_clk);
        ds_addr <= a;
        ds_rd <= 1'b1;
        @(posedge core_clk);
        ds_rd <= 1'b0;
        @(negedge core_clk);
        `CHK("rvalid", h, ds_rvalid)
        if (h) `CHK("rdata", e, ds_rdata)
    endtask

    // op held one edge (ready is high when idle); ticks counted up to done
    task automatic op(input ccr_op_t c, input logic [2:0] n, input logic [11:0] t, input logic [7:0] o);
        int k;
        int ticks;
        @(posedge core_clk);
        op_valid <= 1'b1;
        op_code <= c;
        op_cycles <= n;
        op_target <= t;
        op_offset <= o;
        @(posedge core_clk);
        op_valid <= 1'b0;
        ticks = 0;
        k = 0;
        do begin
            @(negedge core_clk);
            if (mc_tick === 1'b1) ticks++;
            k++;
        end while (op_done !== 1'b1 && k < 80);
        `CHK("ticks", n, 3'(ticks))
        @(posedge core_clk);
        @(negedge core_clk);
    endtask

    task automatic at(input logic [11:0] p, input ccr_ctx_t x);
        `CHK("ip", p, instr_pointer)
        `CHK("ctx", x, ctx_q)
        `CHK("ready", 1'b1, op_ready)
    endtask

    initial begin
        repeat (16) @(posedge core_clk);
        rst <= 1'b0;
        @(negedge core_clk);
        at(CCR_RESET_VECTOR, CCR_CTX_NMI);
        for (i = 0; i < 5; i++) ds_write(amap[i], 8'hA0 + 8'(i));
        for (i = 0; i < 5; i++) ds_read(amap[i], 1'b1, 8'hA0 + 8'(i));
        ds_write(8'h84, 8'h55);
        ds_read(8'h84, 1'b0, 8'h00);
        `CHK("ptr", 8'hA0, pointer_one_q)
        `CHK("ptr2", 8'hA1, pointer_two_q)
        // alu result and nmi flag pair
        @(posedge core_clk);
        alu_we <= 1'b1;
        alu_result <= 8'h00;
        carry_we <= 1'b1;
        carry_in <= 1'b1;
        zero_we <= 1'b1;
        zero_in <= 1'b1;
        @(posedge core_clk);
        alu_we <= 1'b0;
        carry_we <= 1'b0;
        zero_we <= 1'b0;
        @(negedge core_clk);
        `CHK("result", 8'h00, result_q)
        `CHK("carry", 1'b1, carry_out)
        `CHK("zero", 1'b1, zero_out)
        // jump, one fetch step, branch back by two
        op(CCR_OP_JUMP, 3'h2, 12'h100, 8'h00);
        at(12'h100, CCR_CTX_NMI);
        @(posedge core_clk);
        pm_en <= 1'b1;
        repeat (13) @(posedge core_clk);
        pm_en <= 1'b0;
        repeat (2) @(posedge core_clk);
        @(negedge core_clk);
        at(12'h101, CCR_CTX_NMI);
        op(CCR_OP_BRANCH, 3'h4, 12'h000, 8'hFE);
        at(12'h0FF, CCR_CTX_NMI);
        // call, interrupt keeps its own pair, returns restore
        op(CCR_OP_CALL, 3'h5, 12'h200, 8'h00);
        at(12'h200, CCR_CTX_NMI);
        op(CCR_OP_IRQ, 3'h2, 12'h000, 8'h00);
        at(CCR_IRQ_VECTOR, CCR_CTX_IRQ);
        `CHK("carry", 1'b0, carry_out)
        op(CCR_OP_IRQ_EXIT, 3'h2, 12'h000, 8'h00);
        at(12'h200, CCR_CTX_NMI);
        `CHK("carry", 1'b1, carry_out)
        op(CCR_OP_SUB_EXIT, 3'h4, 12'h000, 8'h00);
        at(12'h0FF, CCR_CTX_NMI);
        // seven nested calls lose the oldest return
        for (i = 1; i < 8; i++) op(CCR_OP_CALL, 3'h2, 12'h300 + 12'(i), 8'h00);
        for (i = 6; i > 0; i--) begin
            op(CCR_OP_SUB_EXIT, 3'h2, 12'h000, 8'h00);
            at(12'h300 + 12'(i), CCR_CTX_NMI);
        end
        op(CCR_OP_SUB_EXIT, 3'h2, 12'h000, 8'h00);
        at(12'h302, CCR_CTX_NMI);
        op(CCR_OP_SEQ, 3'h2, 12'h000, 8'h00);
        at(12'h303, CCR_CTX_NMI);
        op(CCR_OP_NMI, 3'h5, 12'h000, 8'h00);
        at(CCR_NMI_VECTOR, CCR_CTX_NMI);
        op(CCR_OP_IRQ_EXIT, 3'h2, 12'h000, 8'h00);
        at(12'h303, CCR_CTX_NMI);
        op(CCR_OP_IRQ_EXIT, 3'h2, 12'h000, 8'h00);
        at(12'h304, CCR_CTX_NORMAL);
        `CHK("carry", 1'b0, carry_out)
        @(posedge core_clk);
        bank_sel <= 2'h2;
        @(posedge core_clk);
        @(negedge core_clk);
        `CHK("bank", 2'h2, pm_bank)
        close_out();
    end
endmodule
